// ---- rtl/backup_mode_and_wdog_select.sv ----
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/100ps
// Overview of operation
// - In backup reset_n, low-supply and warning are low; backup, watchdog flag and CE out high; timebase ignored.
// - In backup mode the active-high reset is driven high.
// - In backup mode the power-fail sense input has no effect on the warning output.
// - Supervision stops whenever the host releases the kick input to high impedance.
// - With the timebase select low the timeout comes from the external-capacitor timebase.
// - The external-capacitor timeout is a long parameterised count standing for 100 seconds.
// - With the timebase select high the internal oscillator gives 100 ms or 1.6 s by timebase input level.
// - A kick input without a transition for the selected timeout yields a fixed 50 ms reset pulse.
// - After any reset with the timebase select high the long timeout applies until the first kick transition after release.
// - Whenever main supply is below battery the comparison is off and the warning is low.
module backup_mode_and_wdog_select
	import supervisor_pkg::*;
#(
	parameter logic [31:0] WD_SHORT = WD_SHORT_CYC,
	parameter logic [31:0] WD_LONG = WD_LONG_CYC,
	parameter logic [31:0] WD_EXT = WD_EXT_CYC,
	parameter logic [31:0] RST_PULSE = RST_PULSE_CYC
)
(
	// Clock and reset
	input wire logic SYS_CLK,
	input wire logic NRST,
	// APB slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// Supply conditions
	input wire logic BACKUP_MODE,
	input wire logic SUPPLY_LOW,
	input wire logic POWER_FAIL_SENSE_INPUT,
	// Watchdog and timebase pins
	input wire logic WATCHDOG_KICK_INPUT,
	input wire logic WATCHDOG_KICK_DRIVEN,
	input wire logic TIMEBASE_SELECT,
	input wire logic TIMEBASE_INPUT,
	// Chip enable gating
	input wire logic CHIP_ENABLE_IN_N,
	output logic CHIP_ENABLE_OUT_N,
	// Supervisor outputs
	output logic RESET_N,
	output logic RESET,
	output logic LOW_SUPPLY_N,
	output logic BACKUP_ACTIVE,
	output logic WATCHDOG_TIMEOUT_FLAG_N,
	output logic POWER_FAIL_WARNING_N
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	sup_state_t state_q;
	sup_out_t out_q;
	logic supv_en_q;
	logic long_q;
	logic kick_prev_q;
	logic [31:0] pulse_cnt_q;
	logic [31:0] prdata_q;
	logic slverr_q;
	logic kick_edge;
	logic wd_run;
	logic wd_restart;
	logic wd_expire;
	logic [31:0] wd_limit;
	logic [31:0] wd_count;
	logic pulse_done;
	logic setup_ph;
	logic wr_ctrl;

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	// Zero wait states; data and error are latched in the setup cycle
	assign setup_ph = PSEL && !PENABLE;
	assign wr_ctrl = PSEL && PENABLE && PWRITE && (PADDR == CTRL_OFS);
	assign PREADY = 1'b1;
	assign PRDATA = prdata_q;
	assign PSLVERR = slverr_q;

	// Read data capture and unmapped-address error
	always_ff @(posedge SYS_CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			prdata_q <= '0;
			slverr_q <= 1'b0;
		end
		else if (setup_ph)
		begin
			prdata_q <= '0;
			slverr_q <= 1'b0;
			unique case (PADDR)
				CTRL_OFS: prdata_q[CTRL_SUPV_EN_BIT] <= supv_en_q;
				STATUS_OFS:
				begin
					prdata_q[STATUS_OUT_LSB +: $bits(sup_out_t)] <= out_q;
					prdata_q[STATUS_STATE_BIT] <= (state_q == ST_PULSE);
					prdata_q[STATUS_LONG_BIT] <= long_q;
					prdata_q[STATUS_RELEASED_BIT] <= !WATCHDOG_KICK_DRIVEN;
				end
				ID_OFS: prdata_q <= ID_VALUE;
				default: slverr_q <= 1'b1;
			endcase
		end
	end

	// Software supervision enable
	always_ff @(posedge SYS_CLK or negedge NRST)
	begin
		if (!NRST)
			supv_en_q <= CTRL_SUPV_EN_RST;
		else if (wr_ctrl)
			supv_en_q <= PWDATA[CTRL_SUPV_EN_BIT];
	end

	// ----------------------------------------
	// Watchdog
	// ----------------------------------------
	// A level only counts while the host drives the pin
	assign kick_edge = WATCHDOG_KICK_DRIVEN && (WATCHDOG_KICK_INPUT != kick_prev_q);

	always_ff @(posedge SYS_CLK or negedge NRST)
	begin
		if (!NRST)
			kick_prev_q <= 1'b0;
		else if (WATCHDOG_KICK_DRIVEN)
			kick_prev_q <= WATCHDOG_KICK_INPUT;
	end

	// Period selection; the pins are don't-care while in backup
	always_comb
	begin
		if (long_q)
			wd_limit = TIMEBASE_SELECT ? WD_LONG : WD_EXT;
		else if (!TIMEBASE_SELECT)
			wd_limit = WD_EXT;
		else
			wd_limit = TIMEBASE_INPUT ? WD_LONG : WD_SHORT;
	end

	// Released pin, software disable or backup pauses supervision
	assign wd_run = (state_q == ST_RUN) && WATCHDOG_KICK_DRIVEN && supv_en_q && !BACKUP_MODE;
	assign wd_restart = kick_edge;

	watchdog_timer #(.CW(32)) u_timer (
		.clk(SYS_CLK),
		.rst_n(NRST),
		.run(wd_run),
		.restart(wd_restart),
		.limit(wd_limit),
		.expire(wd_expire),
		.count(wd_count)
	);

	// Long period held from any reset until the first kick after release
	always_ff @(posedge SYS_CLK or negedge NRST)
	begin
		if (!NRST)
			long_q <= 1'b1;
		else if (state_q == ST_PULSE)
			long_q <= 1'b1;
		else if (kick_edge)
			long_q <= 1'b0;
	end

	// ----------------------------------------
	// Reset sequencing
	// ----------------------------------------
	assign pulse_done = (pulse_cnt_q >= RST_PULSE - 32'h0000_0001) && !SUPPLY_LOW && !BACKUP_MODE;

	// Pulse length counter, held at zero while the supply is bad
	always_ff @(posedge SYS_CLK or negedge NRST)
	begin
		if (!NRST)
			pulse_cnt_q <= '0;
		else if (state_q != ST_PULSE || SUPPLY_LOW || BACKUP_MODE)
			pulse_cnt_q <= '0;
		else
			pulse_cnt_q <= pulse_cnt_q + 32'h0000_0001;
	end

	// Supervisor state
	always_ff @(posedge SYS_CLK or negedge NRST)
	begin
		if (!NRST)
			state_q <= ST_PULSE;
		else
			unique case (state_q)
				ST_RUN:
					if (SUPPLY_LOW || BACKUP_MODE || wd_expire)
						state_q <= ST_PULSE;
				ST_PULSE:
					if (pulse_done)
						state_q <= ST_RUN;
			endcase
	end

	// ----------------------------------------
	// Output levels
	// ----------------------------------------
	// Backup forces every level; comparator is off so sense is not looked at
	always_ff @(posedge SYS_CLK or negedge NRST)
	begin
		if (!NRST)
			out_q <= OUT_RST;
		else if (BACKUP_MODE)
		begin
			out_q.reset_n <= 1'b0;
			out_q.reset_hi <= 1'b1;
			out_q.low_supply_n <= 1'b0;
			out_q.backup_active <= 1'b1;
			out_q.wdog_flag_n <= 1'b1;
			out_q.pf_warn_n <= 1'b0;
			out_q.ce_out_n <= 1'b1;
		end
		else
		begin
			out_q.reset_n <= (state_q == ST_RUN) && !SUPPLY_LOW && !wd_expire;
			out_q.reset_hi <= !((state_q == ST_RUN) && !SUPPLY_LOW && !wd_expire);
			out_q.low_supply_n <= !SUPPLY_LOW;
			out_q.backup_active <= 1'b0;
			// Timeout wins over a low supply in the same cycle so the event is kept
			if (wd_expire)
				out_q.wdog_flag_n <= 1'b0;
			else if (kick_edge || SUPPLY_LOW)
				out_q.wdog_flag_n <= 1'b1;
			out_q.pf_warn_n <= POWER_FAIL_SENSE_INPUT;
			out_q.ce_out_n <= CHIP_ENABLE_IN_N || SUPPLY_LOW;
		end
	end

	assign RESET_N = out_q.reset_n;
	assign RESET = out_q.reset_hi;
	assign LOW_SUPPLY_N = out_q.low_supply_n;
	assign BACKUP_ACTIVE = out_q.backup_active;
	assign WATCHDOG_TIMEOUT_FLAG_N = out_q.wdog_flag_n;
	assign POWER_FAIL_WARNING_N = out_q.pf_warn_n;
	assign CHIP_ENABLE_OUT_N = out_q.ce_out_n;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	AST_BACKUP_LEVELS: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		BACKUP_MODE |=> (!RESET_N && !LOW_SUPPLY_N && BACKUP_ACTIVE && WATCHDOG_TIMEOUT_FLAG_N && CHIP_ENABLE_OUT_N))
		else $error("backup levels wrong");
	AST_BACKUP_RESET_HIGH: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		BACKUP_MODE |=> RESET && (state_q == ST_PULSE))
		else $error("reset not high in backup");
	AST_BACKUP_PF_LOW: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		BACKUP_MODE [*2] |=> !POWER_FAIL_WARNING_N && $stable(POWER_FAIL_WARNING_N))
		else $error("warning follows sense in backup");
	AST_RELEASED_IDLE: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		!WATCHDOG_KICK_DRIVEN |=> (wd_count == 32'h0000_0000) && !wd_expire)
		else $error("watchdog counts while released");
	AST_EXT_TIMEBASE: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		!TIMEBASE_SELECT |-> (wd_limit == WD_EXT))
		else $error("external timebase not used");
	AST_INT_TIMEBASE: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		(TIMEBASE_SELECT && !long_q) |-> (wd_limit == (TIMEBASE_INPUT ? WD_LONG : WD_SHORT)))
		else $error("internal period wrong");
	AST_EXPIRE_RESET: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		wd_expire |=> !RESET_N && RESET && !WATCHDOG_TIMEOUT_FLAG_N && (state_q == ST_PULSE))
		else $error("timeout without reset");
	AST_PULSE_END: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		(state_q == ST_PULSE) && (pulse_cnt_q < RST_PULSE - 32'h0000_0001) |=> (state_q == ST_PULSE))
		else $error("reset pulse too short");
	AST_LONG_AFTER_RESET: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		(state_q == ST_PULSE) ##1 (state_q == ST_RUN) |-> long_q && (wd_limit == (TIMEBASE_SELECT ? WD_LONG : WD_EXT)))
		else $error("long period not applied after reset");
	AST_PF_FOLLOWS: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		!BACKUP_MODE |=> (POWER_FAIL_WARNING_N == $past(POWER_FAIL_SENSE_INPUT)))
		else $error("warning does not follow sense");

	COV_WD_RESET: cover property (@(posedge SYS_CLK) disable iff (!NRST) wd_expire ##1 (state_q == ST_PULSE));
	COV_BACKUP: cover property (@(posedge SYS_CLK) disable iff (!NRST) $rose(BACKUP_MODE));
	COV_SHORT_PERIOD: cover property (@(posedge SYS_CLK) disable iff (!NRST) wd_run && (wd_limit == WD_SHORT));
	COV_RELEASE: cover property (@(posedge SYS_CLK) disable iff (!NRST) $fell(WATCHDOG_KICK_DRIVEN));

endmodule

// ---- rtl/supervisor_pkg.sv ----
package supervisor_pkg;

	// ----------------------------------------
	// Clock and timing
	// ----------------------------------------
	localparam longint unsigned CLK_HZ = 20_000_000;
	localparam longint unsigned WD_SHORT_MS = 100;
	localparam longint unsigned WD_LONG_MS = 1600;
	localparam longint unsigned WD_EXT_S = 100;
	localparam longint unsigned RST_PULSE_MS = 50;
	// Derived cycle counts, whole milliseconds divide exactly at this rate
	localparam logic [31:0] WD_SHORT_CYC = 32'(WD_SHORT_MS * (CLK_HZ / 1000));
	localparam logic [31:0] WD_LONG_CYC = 32'(WD_LONG_MS * (CLK_HZ / 1000));
	localparam logic [31:0] WD_EXT_CYC = 32'(WD_EXT_S * CLK_HZ);
	localparam logic [31:0] RST_PULSE_CYC = 32'(RST_PULSE_MS * (CLK_HZ / 1000));

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [11:0] CTRL_OFS = 12'h000;
	localparam logic [11:0] STATUS_OFS = 12'h004;
	localparam logic [11:0] ID_OFS = 12'h008;
	localparam int CTRL_SUPV_EN_BIT = 0;
	localparam logic CTRL_SUPV_EN_RST = 1'b1;
	localparam logic [31:0] ID_VALUE = 32'h00005a01; // Arbitrary value
	localparam int STATUS_OUT_LSB = 0;
	localparam int STATUS_STATE_BIT = 8;
	localparam int STATUS_LONG_BIT = 9;
	localparam int STATUS_RELEASED_BIT = 10;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic {ST_RUN, ST_PULSE} sup_state_t;

	typedef struct packed {
		logic ce_out_n;
		logic pf_warn_n;
		logic wdog_flag_n;
		logic backup_active;
		logic low_supply_n;
		logic reset_hi;
		logic reset_n;
	} sup_out_t;

	localparam sup_out_t OUT_RST = '{ce_out_n: 1'b1, pf_warn_n: 1'b0, wdog_flag_n: 1'b1,
		backup_active: 1'b0, low_supply_n: 1'b0, reset_hi: 1'b1, reset_n: 1'b0};

endpackage

// ---- rtl/watchdog_timer.sv ----
`timescale 1ns/100ps
module watchdog_timer
	import supervisor_pkg::*;
#(
	parameter int CW = 32
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Control
	input wire logic run,
	input wire logic restart,
	input wire logic [CW-1:0] limit,
	// Status
	output logic expire,
	output logic [CW-1:0] count
);

	logic [CW-1:0] count_q;

	// Expiry on the last cycle of the period; restart dominates
	assign expire = run && !restart && (count_q >= limit - CW'(1));
	assign count = count_q;

	// Period counter, cleared whenever supervision pauses
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			count_q <= '0;
		else if (!run || restart || expire)
			count_q <= '0;
		else
			count_q <= count_q + CW'(1);
	end

endmodule

// ---- verif/host_model.sv ----
`timescale 1ns/100ps
// ----------------------------------------
// Host side of the kick pin
// ----------------------------------------
module host_model
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Commands from bench
	input wire logic toggle,
	input wire logic release_pin,
	// Kick pin
	output logic kick,
	output logic driven
);
	// Toggle on request; a released pin wanders, so stale levels never look valid
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			kick <= 1'b0;
			driven <= 1'b1;
		end
		else
		begin
			driven <= !release_pin;
			if (release_pin || toggle)
				kick <= !kick;
		end
	end
endmodule

// ---- verif/tb.sv ----
`timescale 1ns/100ps
module tb
	import supervisor_pkg::*;
;
	// ----------------------------------------
	// Stimulus, model and checks
	// ----------------------------------------
	localparam int SHORT = 20, LONG = 40, EXT = 60, PULSE = 10, LIM = 150;
	logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, pready, pslverr, err;
	logic backup = 1'b0, slow = 1'b0, pf_sense = 1'b1, tsel = 1'b1, tin = 1'b0, ce_in = 1'b0;
	logic tog = 1'b0, rel = 1'b0, kick, kdrv;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	// Each output port drives its own bit, so this is a net
	wire [6:0] outs;
	logic [6:0] msk;
	logic [15:0] lfsr = 16'h0043;
	int mismatches = 0, samples_checked = 0, cyc = 0, n, ex;
	// Half period of 25 ns gives 20 MHz
	always #25 clk = ~clk;
	backup_mode_and_wdog_select #(.WD_SHORT(SHORT), .WD_LONG(LONG), .WD_EXT(EXT), .RST_PULSE(PULSE))
	u_backup_mode_and_wdog_select (.SYS_CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.BACKUP_MODE(backup), .SUPPLY_LOW(slow), .POWER_FAIL_SENSE_INPUT(pf_sense), .WATCHDOG_KICK_INPUT(kick),
		.WATCHDOG_KICK_DRIVEN(kdrv), .TIMEBASE_SELECT(tsel), .TIMEBASE_INPUT(tin),
		.CHIP_ENABLE_IN_N(ce_in), .CHIP_ENABLE_OUT_N(outs[6]), .RESET_N(outs[0]), .RESET(outs[1]),
		.LOW_SUPPLY_N(outs[2]), .BACKUP_ACTIVE(outs[3]), .WATCHDOG_TIMEOUT_FLAG_N(outs[4]),
		.POWER_FAIL_WARNING_N(outs[5]));
	host_model u_host_model (.clk(clk), .rst_n(nrst), .toggle(tog), .release_pin(rel), .kick(kick), .driven(kdrv));
	// Random source and expected output levels
	function automatic logic [15:0] nxt(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	function automatic logic [6:0] exp_outs(input logic b, p, c, s);
		return b ? 7'h5a : {c | s, p, 2'b00, !s, 2'b00};
	endfunction
	task end_sim;
		$display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
		if (mismatches == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, g);
		samples_checked++;
		if (g !== e)
		begin
			mismatches++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask
	task chk_rng(input string nm, input int lo, hi, g);
		samples_checked++;
		if (g < lo || g > hi)
		begin
			mismatches++;
			$display("MISMATCH %s exp %0d..%0d got %0d", nm, lo, hi, g);
		end
	endtask
	// APB master: hold the request until pready is seen high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		// Only the bench timeout ends the wait for ready
		do
			@(posedge clk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task kick_once;
		@(posedge clk);
		tog <= 1'b1;
		@(posedge clk);
		tog <= 1'b0;
	endtask
	// Count cycles until reset output reaches a level, sampled mid-cycle
	task wait_lvl(input logic v);
		n = 0;
		while (outs[0] !== v && n < LIM)
		begin
			@(negedge clk);
			n++;
		end
	endtask
	// Hang guard, far beyond the expected run
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			mismatches++;
			end_sim();
		end
	end
	initial
	begin
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		wait_lvl(1'b1);
		chk_rng("boot pulse", PULSE, PULSE + 2, n);
		wait_lvl(1'b0);
		chk_rng("post reset period", LONG - 2, LONG + 4, n);
		chk("timeout flag", 32'h0, outs[4]);
		chk("reset high", 32'h1, outs[1]);
		wait_lvl(1'b1);
		chk_rng("timeout pulse", PULSE, PULSE + 2, n);
		// Short, long, then capacitor timebase; lengthening beats releasing
		for (int m = 0; m < 3; m++)
		begin
			@(posedge clk);
			tsel <= (m < 2);
			tin <= (m == 1);
			ex = (m == 0) ? SHORT : (m == 1) ? LONG : EXT;
			repeat (12)
			begin
				lfsr = nxt(lfsr);
				repeat (int'(lfsr[3:0])) @(posedge clk);
				kick_once();
				@(negedge clk);
				chk("no reset while kicked", 32'h1, outs[0]);
			end
			chk("flag cleared", 32'h1, outs[4]);
			wait_lvl(1'b0);
			chk_rng("selected period", ex, ex + 4, n);
			wait_lvl(1'b1);
		end
		kick_once();
		@(posedge clk);
		rel <= 1'b1;
		wait_lvl(1'b0);
		chk_rng("released pin", LIM, LIM, n);
		// Levels idle, no pulse, normal period, released flag set
		apb(1'b0, STATUS_OFS, 32'h00000000);
		chk("status released", 32'h00000435, rd);
		@(posedge clk);
		rel <= 1'b0;
		apb(1'b0, ID_OFS, 32'h0);
		chk("id", ID_VALUE, rd);
		apb(1'b1, 12'h00c, 32'hffffffff);
		apb(1'b0, 12'h00c, 32'h0);
		chk("unmapped err", 32'h1, err);
		chk("unmapped data", 32'h0, rd);
		apb(1'b0, CTRL_OFS, 32'h0);
		chk("ctrl reset", 32'h1, rd);
		apb(1'b1, CTRL_OFS, 32'h0);
		wait_lvl(1'b0);
		chk_rng("paused", LIM, LIM, n);
		apb(1'b1, CTRL_OFS, 32'h1);
		// Random supply and pin levels, backup forcing included
		repeat (40)
		begin
			@(posedge clk);
			lfsr = nxt(lfsr);
			backup <= lfsr[0];
			pf_sense <= lfsr[1];
			ce_in <= lfsr[2];
			tsel <= lfsr[3];
			tin <= lfsr[4];
			tog <= lfsr[5];
			slow <= lfsr[6];
			msk = lfsr[0] ? 7'h7f : 7'h6c;
			repeat (2) @(posedge clk);
			@(negedge clk);
			chk("outputs", exp_outs(lfsr[0], lfsr[1], lfsr[2], lfsr[6]) & msk, outs & msk);
		end
		end_sim();
	end
endmodule
